// file: ssc_pkg.sv
package ssc_pkg;
    typedef enum logic [1:0] {
        SSC_LVL_LOW  = 2'h0,
        SSC_LVL_HIGH = 2'h1,
        SSC_LVL_OPEN = 2'h2
    } ssc_level_t;

    typedef enum logic [2:0] {
        SSC_ST_IDLE   = 3'h1,
        SSC_ST_SAMPLE = 3'h2,
        SSC_ST_HOLD   = 3'h4
    } ssc_state_t;

    localparam logic [3:0] SSC_DECAY_LOW  = 4'h4;
    localparam logic [3:0] SSC_DECAY_HIGH = 4'h7;
    localparam logic [3:0] SSC_DECAY_OPEN = 4'hA;
    localparam logic [3:0] SSC_DECAY_RST  = 4'h0;
    localparam logic [3:0] SSC_RES_FULL   = 4'h8;
    localparam logic [3:0] SSC_RES_HALF   = 4'h7;
    localparam logic [3:0] SSC_RES_QUART  = 4'h6;
    localparam logic [3:0] SSC_RES_16     = 4'h4;
    localparam logic [3:0] SSC_RES_RST    = 4'h0;
    localparam int         SSC_POS_W      = 32;
    localparam logic [3:0] SSC_SETTLE_CYC = 4'h3;
endpackage

// file: ssc_standalone_cfg.sv
`timescale 1ns/100ps
module ssc_standalone_cfg (
    input  wire logic                       sys_clk,
    input  wire logic                       nrst,
    input  wire logic                       serial_select,
    input  wire logic                       step_dir_select_pd,
    input  wire logic                       step_dir_select_pu,
    input  wire logic                       off_time_strap_pd,
    input  wire logic                       off_time_strap_pu,
    input  wire logic                       resolution_strap_low_pd,
    input  wire logic                       resolution_strap_low_pu,
    input  wire logic                       resolution_strap_high_pd,
    input  wire logic                       resolution_strap_high_pu,
    input  wire logic                       step_in,
    input  wire logic                       dir_in,
    input  wire logic                       driver_error,
    input  wire logic                       index_hit,
    output logic                            standalone_r,
    output logic                            spi_enable_r,
    output logic                            uart_enable_r,
    output logic                            step_dir_select_r,
    output logic                            cfg_valid_r,
    output logic [3:0]                      slow_decay_time_r,
    output logic [3:0]                      microstep_resolution_code_r,
    output logic                            intpol_r,
    output logic                            en_pwm_mode_r,
    output logic                            fault_output_select_r,
    output logic                            index_output_select_r,
    output logic [ssc_pkg::SSC_POS_W-1:0]   position_r,
    output logic                            first_fault_pin_oe_r,
    output logic                            second_index_pin_oe_r
);
    ////////////////////////////////////////////////////////////////////////////////
    ssc_pkg::ssc_level_t lvl_sd;
    ssc_pkg::ssc_level_t lvl_off;
    ssc_pkg::ssc_level_t lvl_lo;
    ssc_pkg::ssc_level_t lvl_hi;
    ssc_pkg::ssc_state_t state_r;
    ssc_pkg::ssc_state_t state_nxt;
    logic [3:0]          settle_r;
    logic                step_d_r;
    logic [5:0]          res_bits;

    ssc_tristate_detect u_det_sd (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .probe_pd (step_dir_select_pd),
        .probe_pu (step_dir_select_pu),
        .level    (lvl_sd)
    );
    ssc_tristate_detect u_det_off (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .probe_pd (off_time_strap_pd),
        .probe_pu (off_time_strap_pu),
        .level    (lvl_off)
    );
    ssc_tristate_detect u_det_lo (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .probe_pd (resolution_strap_low_pd),
        .probe_pu (resolution_strap_low_pu),
        .level    (lvl_lo)
    );
    ssc_tristate_detect u_det_hi (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .probe_pd (resolution_strap_high_pd),
        .probe_pu (resolution_strap_high_pu),
        .level    (lvl_hi)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] off_decode(input ssc_pkg::ssc_level_t l);
        case (l)
            ssc_pkg::SSC_LVL_LOW:  off_decode = ssc_pkg::SSC_DECAY_LOW;
            ssc_pkg::SSC_LVL_HIGH: off_decode = ssc_pkg::SSC_DECAY_HIGH;
            default:               off_decode = ssc_pkg::SSC_DECAY_OPEN;
        endcase
    endfunction

    // Returns the resolution code, the interpolation flag and the pwm enable, in that order from the top.
    function automatic logic [5:0] res_decode(input ssc_pkg::ssc_level_t hi, input ssc_pkg::ssc_level_t lo);
        case (hi)
            ssc_pkg::SSC_LVL_LOW: begin
                case (lo)
                    ssc_pkg::SSC_LVL_LOW:  res_decode = {ssc_pkg::SSC_RES_FULL, 2'b00};
                    ssc_pkg::SSC_LVL_HIGH: res_decode = {ssc_pkg::SSC_RES_HALF, 2'b00};
                    default:               res_decode = {ssc_pkg::SSC_RES_HALF, 2'b10};
                endcase
            end
            ssc_pkg::SSC_LVL_HIGH: begin
                case (lo)
                    ssc_pkg::SSC_LVL_LOW:  res_decode = {ssc_pkg::SSC_RES_QUART, 2'b00};
                    ssc_pkg::SSC_LVL_HIGH: res_decode = {ssc_pkg::SSC_RES_16, 2'b00};
                    default:               res_decode = {ssc_pkg::SSC_RES_QUART, 2'b10};
                endcase
            end
            default: begin
                case (lo)
                    ssc_pkg::SSC_LVL_LOW:  res_decode = {ssc_pkg::SSC_RES_16, 2'b10};
                    ssc_pkg::SSC_LVL_HIGH: res_decode = {ssc_pkg::SSC_RES_QUART, 2'b11};
                    default:               res_decode = {ssc_pkg::SSC_RES_16, 2'b11};
                endcase
            end
        endcase
    endfunction

    assign res_bits = res_decode(lvl_hi, lvl_lo);

    ////////////////////////////////////////////////////////////////////////////////
    // Waits for the detectors to settle after reset or mode entry, then latches once.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ssc_pkg::SSC_ST_IDLE: begin
                if (!serial_select) begin
                    state_nxt = ssc_pkg::SSC_ST_SAMPLE;
                end
            end
            ssc_pkg::SSC_ST_SAMPLE: begin
                if (serial_select) begin
                    state_nxt = ssc_pkg::SSC_ST_IDLE;
                end else if (settle_r == ssc_pkg::SSC_SETTLE_CYC) begin
                    state_nxt = ssc_pkg::SSC_ST_HOLD;
                end
            end
            ssc_pkg::SSC_ST_HOLD: begin
                if (serial_select) begin
                    state_nxt = ssc_pkg::SSC_ST_IDLE;
                end
            end
            default: state_nxt = ssc_pkg::SSC_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ssc_pkg::SSC_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            settle_r <= 4'h0;
        end else if (state_r == ssc_pkg::SSC_ST_SAMPLE) begin
            settle_r <= settle_r + 4'h1;
        end else begin
            settle_r <= 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            standalone_r          <= 1'b0;
            spi_enable_r          <= 1'b0;
            uart_enable_r         <= 1'b0;
            fault_output_select_r <= 1'b0;
            index_output_select_r <= 1'b0;
        end else begin
            standalone_r          <= !serial_select;
            spi_enable_r          <= serial_select;
            uart_enable_r         <= serial_select;
            fault_output_select_r <= !serial_select;
            index_output_select_r <= !serial_select;
        end
    end

    // An open select pin reads as high; only a firm low selects the other mode.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            step_dir_select_r <= 1'b1;
        end else begin
            step_dir_select_r <= (lvl_sd != ssc_pkg::SSC_LVL_LOW);
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_valid_r                 <= 1'b0;
            slow_decay_time_r           <= ssc_pkg::SSC_DECAY_RST;
            microstep_resolution_code_r <= ssc_pkg::SSC_RES_RST;
            intpol_r                    <= 1'b0;
            en_pwm_mode_r               <= 1'b0;
        end else if (state_nxt == ssc_pkg::SSC_ST_HOLD && state_r == ssc_pkg::SSC_ST_SAMPLE) begin
            cfg_valid_r       <= 1'b1;
            slow_decay_time_r <= off_decode(lvl_off);
            {microstep_resolution_code_r, intpol_r} <= res_bits[5:1];
            en_pwm_mode_r     <= res_bits[0];
        end else if (state_nxt == ssc_pkg::SSC_ST_IDLE) begin
            cfg_valid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            step_d_r   <= 1'b0;
            position_r <= '0;
        end else begin
            step_d_r <= step_in;
            if (cfg_valid_r && step_in && !step_d_r) begin
                if (dir_in) begin
                    position_r <= position_r - ssc_pkg::SSC_POS_W'(1);
                end else begin
                    position_r <= position_r + ssc_pkg::SSC_POS_W'(1);
                end
            end
        end
    end

    // Open drain: enable pulls the pin low while serial_select is low and the flagged condition is active.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            first_fault_pin_oe_r  <= 1'b0;
            second_index_pin_oe_r <= 1'b0;
        end else begin
            first_fault_pin_oe_r  <= !serial_select && driver_error;
            second_index_pin_oe_r <= !serial_select && index_hit;
        end
    end
endmodule

// file: ssc_standalone_cfg_props.sv
`timescale 1ns/100ps
module ssc_standalone_cfg_props (
    input wire logic                             sys_clk,
    input wire logic                             nrst,
    input wire logic                             serial_select,
    input wire logic                             step_in,
    input wire logic                             driver_error,
    input wire logic                             standalone_r,
    input wire logic                             spi_enable_r,
    input wire logic                             uart_enable_r,
    input wire logic                             cfg_valid_r,
    input wire logic [3:0]                       slow_decay_time_r,
    input wire logic [3:0]                       microstep_resolution_code_r,
    input wire logic                             intpol_r,
    input wire logic                             en_pwm_mode_r,
    input wire logic                             fault_output_select_r,
    input wire logic                             index_output_select_r,
    input wire logic [ssc_pkg::SSC_POS_W-1:0]    position_r,
    input wire logic                             first_fault_pin_oe_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_serial_off;
        !serial_select |=> !spi_enable_r && !uart_enable_r;
    endproperty
    a_serial_off: assert property (p_serial_off) else $error("serial port left enabled");
    property p_valid_lat;
        $fell(serial_select) ##1 !serial_select[*4] |-> !cfg_valid_r ##1 cfg_valid_r;
    endproperty
    a_valid_lat: assert property (p_valid_lat) else $error("config not latched in time");
    property p_selects;
        standalone_r |-> fault_output_select_r && index_output_select_r;
    endproperty
    a_selects: assert property (p_selects) else $error("diagnostic selects not forced");
    property p_slow_decay_time;
        cfg_valid_r |-> slow_decay_time_r inside {4'h4, 4'h7, 4'hA};
    endproperty
    a_slow_decay_time: assert property (p_slow_decay_time) else $error("illegal slow decay time");
    property p_pwm;
        en_pwm_mode_r |-> intpol_r && (microstep_resolution_code_r inside {4'h6, 4'h4});
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm chopper with wrong resolution");
    property p_hold;
        cfg_valid_r && $past(cfg_valid_r) |-> $stable({slow_decay_time_r, microstep_resolution_code_r, intpol_r, en_pwm_mode_r});
    endproperty
    a_hold: assert property (p_hold) else $error("config changed while held");
    property p_idle_pos;
        (!cfg_valid_r)[*3] |-> $stable(position_r);
    endproperty
    a_idle_pos: assert property (p_idle_pos) else $error("position moved without config");
    property p_step;
        $rose(step_in) && cfg_valid_r |-> ##[1:2] $changed(position_r);
    endproperty
    a_step: assert property (p_step) else $error("step pulse not counted");
    property p_fault_oe;
        !serial_select && driver_error |=> first_fault_pin_oe_r;
    endproperty
    a_fault_oe: assert property (p_fault_oe) else $error("fault pin not pulled low");
    c_valid: cover property ($rose(cfg_valid_r));
    c_pwm: cover property (cfg_valid_r && en_pwm_mode_r);
    c_step: cover property ($changed(position_r));
endmodule
bind ssc_standalone_cfg ssc_standalone_cfg_props chk_u (.sys_clk, .nrst, .serial_select, .step_in, .driver_error,
    .standalone_r, .spi_enable_r, .uart_enable_r, .cfg_valid_r, .slow_decay_time_r, .microstep_resolution_code_r,
    .intpol_r, .en_pwm_mode_r, .fault_output_select_r, .index_output_select_r, .position_r, .first_fault_pin_oe_r);

// file: ssc_step_source.sv
`timescale 1ns/100ps
module ssc_step_source (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic       dir,
    input  wire logic [7:0] count,
    output logic            step_out,
    output logic            dir_out
);
    logic [8:0] left_r = 9'h000;
    initial step_out = 1'b0;
    initial dir_out = 1'b0;
    // Each step is one cycle high and one low; direction only changes before a burst starts.
    always @(posedge sys_clk) begin
        if (go && left_r == 9'h000) begin
            left_r <= {count, 1'b0};
            dir_out <= dir;
        end else if (left_r != 9'h000) begin
            left_r <= left_r - 9'h001;
        end
        step_out <= (left_r != 9'h000) && !left_r[0];
    end
endmodule

// file: ssc_tristate_detect.sv
`timescale 1ns/100ps
// Classifies one strap from two probe samples: pin sensed with pull-down and with pull-up.
module ssc_tristate_detect (
    input  wire logic              sys_clk,
    input  wire logic              nrst,
    input  wire logic              probe_pd,
    input  wire logic              probe_pu,
    output ssc_pkg::ssc_level_t    level
);
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            level <= ssc_pkg::SSC_LVL_OPEN;
        end else if (probe_pd && probe_pu) begin
            level <= ssc_pkg::SSC_LVL_HIGH;
        end else if (!probe_pd && !probe_pu) begin
            level <= ssc_pkg::SSC_LVL_LOW;
        end else begin
            level <= ssc_pkg::SSC_LVL_OPEN;
        end
    end
endmodule

// file: standalone_strap_config_bench.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; $display("[ERR] %s exp=%0h got=%0h", nm, ex, got); end end
module standalone_strap_config_bench;
    localparam ssc_pkg::ssc_level_t L = ssc_pkg::SSC_LVL_LOW;
    localparam ssc_pkg::ssc_level_t H = ssc_pkg::SSC_LVL_HIGH;
    localparam ssc_pkg::ssc_level_t O = ssc_pkg::SSC_LVL_OPEN;
    typedef struct packed {
        ssc_pkg::ssc_level_t hi, lo, ot;
        logic [3:0]          dec, res;
        logic                ip, pwm;
    } ssc_row_t;
    ssc_row_t rows [9] = '{'{L, L, L, 4'h4, 4'h8, 1'b0, 1'b0}, '{L, H, H, 4'h7, 4'h7, 1'b0, 1'b0},
        '{L, O, O, 4'hA, 4'h7, 1'b1, 1'b0}, '{H, L, L, 4'h4, 4'h6, 1'b0, 1'b0}, '{H, H, H, 4'h7, 4'h4, 1'b0, 1'b0},
        '{H, O, O, 4'hA, 4'h6, 1'b1, 1'b0}, '{O, L, L, 4'h4, 4'h4, 1'b1, 1'b0}, '{O, H, H, 4'h7, 4'h6, 1'b1, 1'b1},
        '{O, O, O, 4'hA, 4'h4, 1'b1, 1'b1}};
    int error_cnt = 0;
    int check_count = 0;
    logic sys_clk, nrst, serial_select, driver_error, index_hit, go, dir, step_in, dir_in;
    logic step_dir_select_pd, step_dir_select_pu, off_time_strap_pd, off_time_strap_pu;
    logic resolution_strap_low_pd, resolution_strap_low_pu, resolution_strap_high_pd, resolution_strap_high_pu;
    logic standalone_r, spi_enable_r, uart_enable_r, step_dir_select_r, cfg_valid_r, intpol_r, en_pwm_mode_r;
    logic fault_output_select_r, index_output_select_r, first_fault_pin_oe_r, second_index_pin_oe_r;
    logic [3:0]  slow_decay_time_r, microstep_resolution_code_r;
    logic [7:0]  cnt;
    logic [31:0] position_r;
    ssc_standalone_cfg dut_u (.sys_clk, .nrst, .serial_select, .step_dir_select_pd, .step_dir_select_pu,
        .off_time_strap_pd, .off_time_strap_pu, .resolution_strap_low_pd, .resolution_strap_low_pu,
        .resolution_strap_high_pd, .resolution_strap_high_pu, .step_in, .dir_in, .driver_error, .index_hit,
        .standalone_r, .spi_enable_r, .uart_enable_r, .step_dir_select_r, .cfg_valid_r, .slow_decay_time_r,
        .microstep_resolution_code_r, .intpol_r, .en_pwm_mode_r, .fault_output_select_r, .index_output_select_r,
        .position_r, .first_fault_pin_oe_r, .second_index_pin_oe_r);
    ssc_step_source src_u (.sys_clk, .go, .dir, .count(cnt), .step_out(step_in), .dir_out(dir_in));
    task automatic final_report();
        if (error_cnt == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic lvl(input ssc_pkg::ssc_level_t v, output logic pd, output logic pu);
        pd = (v == H);
        pu = (v != L);
    endtask
    task automatic wait_valid(input logic v);
        int n;
        n = 0;
        while (cfg_valid_r !== v && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (cfg_valid_r !== v) begin
            error_cnt++;
            $display("[ERR] cfg_valid_r exp=%0h got=%0h", v, cfg_valid_r);
            final_report();
        end
    endtask
    task automatic steps(input logic d, input logic [7:0] k);
        @(negedge sys_clk);
        {go, dir, cnt} = {1'b1, d, k};
        @(negedge sys_clk);
        go = 1'b0;
        repeat (2 * k + 4) @(negedge sys_clk);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    initial begin
        {nrst, serial_select, driver_error, index_hit, go, dir, cnt} = {1'b0, 1'b1, 12'h000};
        {step_dir_select_pd, step_dir_select_pu, off_time_strap_pd, off_time_strap_pu} = 4'h5;
        {resolution_strap_low_pd, resolution_strap_low_pu, resolution_strap_high_pd, resolution_strap_high_pu} = 4'h5;
        repeat (3) @(negedge sys_clk);
        `CHK("reset_cfg_valid", 1'b0, cfg_valid_r)
        repeat (3) @(negedge sys_clk);
        nrst = 1'b1;
        foreach (rows[i]) begin
            serial_select = 1'b1;
            lvl(rows[i].hi, resolution_strap_high_pd, resolution_strap_high_pu);
            lvl(rows[i].lo, resolution_strap_low_pd, resolution_strap_low_pu);
            lvl(rows[i].ot, off_time_strap_pd, off_time_strap_pu);
            wait_valid(1'b0);
            repeat (3) @(negedge sys_clk);
            `CHK("spi_enable_r", 1'b1, spi_enable_r)
            serial_select = 1'b0;
            wait_valid(1'b1);
            `CHK("slow_decay_time_r", rows[i].dec, slow_decay_time_r)
            `CHK("microstep_resolution_code_r", rows[i].res, microstep_resolution_code_r)
            `CHK("intpol_r", rows[i].ip, intpol_r)
            `CHK("en_pwm_mode_r", rows[i].pwm, en_pwm_mode_r)
            `CHK("uart_enable_r", 1'b0, uart_enable_r)
            `CHK("standalone_r", 1'b1, standalone_r)
            `CHK("fault_output_select_r", 1'b1, fault_output_select_r)
            `CHK("index_output_select_r", 1'b1, index_output_select_r)
        end
        `CHK("step_dir_select_r", 1'b1, step_dir_select_r)
        {step_dir_select_pu, off_time_strap_pu, resolution_strap_low_pu, resolution_strap_high_pu} = 4'h0;
        repeat (6) @(negedge sys_clk);
        `CHK("step_dir_select_low", 1'b0, step_dir_select_r)
        `CHK("held_decay", 4'hA, slow_decay_time_r)
        `CHK("held_resolution", 4'h4, microstep_resolution_code_r)
        `CHK("held_pwm", 1'b1, en_pwm_mode_r)
        steps(1'b0, 8'h05);
        `CHK("position_up", 32'h00000005, position_r)
        steps(1'b1, 8'h03);
        `CHK("position_down", 32'h00000002, position_r)
        {driver_error, index_hit} = 2'h3;
        repeat (2) @(negedge sys_clk);
        `CHK("first_fault_pin_oe_r", 1'b1, first_fault_pin_oe_r)
        `CHK("second_index_pin_oe_r", 1'b1, second_index_pin_oe_r)
        serial_select = 1'b1;
        wait_valid(1'b0);
        steps(1'b0, 8'h04);
        `CHK("position_idle", 32'h00000002, position_r)
        `CHK("fault_oe_off", 1'b0, first_fault_pin_oe_r)
        nrst = 1'b0;
        @(negedge sys_clk);
        `CHK("rst_position", 32'h00000000, position_r)
        `CHK("rst_step_dir_select_r", 1'b1, step_dir_select_r)
        `CHK("rst_standalone_r", 1'b0, standalone_r)
        `CHK("rst_fault_output_select_r", 1'b0, fault_output_select_r)
        `CHK("rst_en_pwm_mode_r", 1'b0, en_pwm_mode_r)
        @(negedge sys_clk);
        nrst = 1'b1;
        repeat (2) @(negedge sys_clk);
        `CHK("post_rst_cfg_valid", 1'b0, cfg_valid_r)
        final_report();
    end
endmodule
